// >>> logic/fcr_pkg.sv
// Package for the flash clock ratio and option flags block.
// Assumes a byte-wide register port on the 100 MHz bus clock.
`default_nettype none
package fcr_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] FCR_ADDR_RATIO   = 4'h0;
	localparam logic [3:0] FCR_ADDR_OPTIONS = 4'h1;
	localparam logic [3:0] FCR_ADDR_STATUS  = 4'h2;
	localparam logic [3:0] FCR_ADDR_KEYCTL  = 4'h3;
	localparam logic [3:0] FCR_ADDR_KEYDATA = 4'h4;
	// Clock ratio fields
	localparam int FCR_RATIO_WRITTEN_BIT = 7;
	localparam int FCR_PRESCALE_BIT      = 6;
	localparam int FCR_DIV_MSB           = 5;
	localparam logic [7:0] FCR_RATIO_RESET = 8'h00;
	// Option fields
	localparam int FCR_KEY_EN_BIT   = 7;
	localparam int FCR_NORED_BIT    = 6;
	localparam logic [1:0] FCR_UNSECURED_CODE = 2'h2;
	localparam logic [7:0] FCR_OPT_RESET = 8'h00;
	// Status fields
	localparam int FCR_STAT_ACCERR_BIT = 0;
	localparam int FCR_STAT_SECURE_BIT = 1;
	localparam int FCR_STAT_KEYOK_BIT  = 2;
	// Key control
	localparam int FCR_KEYCTL_ACC_BIT  = 0;
	localparam logic [2:0] FCR_KEY_LAST = 3'h7;
	localparam logic [3:0] FCR_KEY_BYTES = 4'h8;
	// Prescale ratio
	localparam logic [2:0] FCR_PRESCALE_LAST = 3'h7;
	// Pulse time limits in ns and cycles at 100 MHz
	localparam int FCR_CLK_PERIOD_NS = 10;
	localparam int FCR_PULSE_MIN_NS  = 5000;
	localparam int FCR_PULSE_MAX_NS  = 6700;
	localparam int FCR_PULSE_MIN_CYC = (FCR_PULSE_MIN_NS + FCR_CLK_PERIOD_NS - 1)
		/ FCR_CLK_PERIOD_NS;
	localparam int FCR_PULSE_MAX_CYC = FCR_PULSE_MAX_NS / FCR_CLK_PERIOD_NS;
	// Reset-time loader states
	typedef enum logic [2:0] {
		FCR_ST_LOAD = 3'h1,
		FCR_ST_RUN  = 3'h2,
		FCR_ST_IDLE = 3'h4
	} fcr_state_e;
endpackage
`default_nettype wire

// >>> logic/fcr_flash_ctrl.sv
// Flash clock ratio register, option flags, security and backdoor key.
// Assumes nonvolatile bytes and key are presented stably from flash.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`default_nettype none
module fcr_flash_ctrl
	import fcr_pkg::*;
(
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       reset_in,
	// Register port
	input  wire logic [3:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_write_in,
	input  wire logic       reg_read_in,
	input  wire logic       reg_from_debug_in,
	output logic      [7:0] reg_rdata_out,
	// Nonvolatile contents
	input  wire logic [7:0] nonvolatile_options_byte_in,
	input  wire logic [63:0] backdoor_compare_key_in,
	// Sequencer side
	input  wire logic       pe_request_in,
	input  wire logic       blank_check_ok_in,
	output logic            pe_accept_out,
	output logic            flash_clock_pulse_out,
	// Security input and outputs
	input  wire logic       access_unsecured_in,
	output logic            access_block_out,
	output logic            secure_out,
	output logic            vector_redirect_disable_out
);
	logic [7:0]  nvm_clock_ratio_ff;
	logic [7:0]  flash_option_flags_ff;
	logic        access_error_flag_ff;
	logic        key_access_ff;
	logic [2:0]  key_index_ff;
	logic        key_mismatch_ff;
	logic        key_ok_ff;
	logic [2:0]  prescale_ff;
	logic [5:0]  divide_ff;
	logic        pulse_ff;
	logic [7:0]  rdata_ff;
	fcr_state_e  state_ff;
	fcr_state_e  nxt_state;
	logic        wr_ratio;
	logic        wr_keyctl;
	logic        wr_keydata;
	logic        wr_status;
	logic        prescale_tick;
	logic        ratio_written;
	logic        secure;
	logic        key_done;
	logic        key_start;
	logic [9:0]  gap_cnt_ff;
	logic        gap_seen_ff;

	function automatic logic [7:0] key_byte(input logic [63:0] key, input logic [2:0] idx);
		key_byte = key[{idx, 3'h0} +: 8];
	endfunction

	// Expected cycles between flash clock pulses
	function automatic logic [9:0] flash_period(input logic [7:0] ratio);
		logic [9:0] base;
		base = {4'h0, ratio[FCR_DIV_MSB:0]} + 10'h001;
		flash_period = ratio[FCR_PRESCALE_BIT] ? {base[6:0], 3'h0} : base;
	endfunction

	assign wr_ratio      = reg_write_in && (reg_addr_in == FCR_ADDR_RATIO);
	assign wr_keyctl     = reg_write_in && (reg_addr_in == FCR_ADDR_KEYCTL);
	assign wr_status     = reg_write_in && (reg_addr_in == FCR_ADDR_STATUS);
	assign wr_keydata    = reg_write_in && (reg_addr_in == FCR_ADDR_KEYDATA)
		&& key_access_ff && !reg_from_debug_in;
	assign ratio_written = nvm_clock_ratio_ff[FCR_RATIO_WRITTEN_BIT];

	// Reset-time loader
	always_comb begin
		case (state_ff)
			FCR_ST_LOAD: nxt_state = FCR_ST_RUN;
			FCR_ST_RUN:  nxt_state = FCR_ST_RUN;
			default:     nxt_state = FCR_ST_LOAD;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_ff <= FCR_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			nvm_clock_ratio_ff <= FCR_RATIO_RESET;
		end else if (wr_ratio && !ratio_written) begin
			nvm_clock_ratio_ff <= {1'b1, reg_wdata_in[FCR_PRESCALE_BIT:0]};
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			prescale_ff <= 3'h0;
		end else begin
			prescale_ff <= prescale_ff + 3'h1;
		end
	end
	assign prescale_tick = nvm_clock_ratio_ff[FCR_PRESCALE_BIT] ?
		(prescale_ff == FCR_PRESCALE_LAST) : 1'b1;

	always_ff @(posedge clock_in) begin
		if (reset_in || !ratio_written) begin
			divide_ff <= 6'h00;
			pulse_ff  <= 1'b0;
		end else if (prescale_tick) begin
			if (divide_ff == nvm_clock_ratio_ff[FCR_DIV_MSB:0]) begin
				divide_ff <= 6'h00;
				pulse_ff  <= 1'b1;
			end else begin
				divide_ff <= divide_ff + 6'h01;
				pulse_ff  <= 1'b0;
			end
		end else begin
			pulse_ff <= 1'b0;
		end
	end
	assign flash_clock_pulse_out = pulse_ff;

	assign pe_accept_out = pe_request_in && ratio_written;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			access_error_flag_ff <= 1'b0;
		end else if (pe_request_in && !ratio_written) begin
			access_error_flag_ff <= 1'b1;
		end else if (wr_status && reg_wdata_in[FCR_STAT_ACCERR_BIT]) begin
			access_error_flag_ff <= 1'b0;
		end
	end

	// Key entry control
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			key_access_ff <= 1'b0;
		end else if (wr_keyctl && !reg_from_debug_in) begin
			key_access_ff <= reg_wdata_in[FCR_KEYCTL_ACC_BIT];
		end
	end
	assign key_done  = wr_keyctl && key_access_ff && !reg_from_debug_in
		&& !reg_wdata_in[FCR_KEYCTL_ACC_BIT];
	assign key_start = wr_keyctl && !reg_from_debug_in && reg_wdata_in[FCR_KEYCTL_ACC_BIT];

	always_ff @(posedge clock_in) begin
		if (reset_in || key_start) begin
			key_index_ff    <= 3'h0;
			key_mismatch_ff <= 1'b0;
			key_ok_ff       <= 1'b0;
		end else if (wr_keydata) begin
			key_index_ff <= key_index_ff + 3'h1;
			if (reg_wdata_in != key_byte(backdoor_compare_key_in, key_index_ff)) begin
				key_mismatch_ff <= 1'b1;
			end
			if (key_index_ff == FCR_KEY_LAST) begin
				key_ok_ff <= 1'b1;
			end
		end else if (key_done) begin
			key_ok_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			flash_option_flags_ff <= FCR_OPT_RESET;
		end else if (state_ff == FCR_ST_LOAD) begin
			flash_option_flags_ff <= nonvolatile_options_byte_in;
		end else if (blank_check_ok_in) begin
			flash_option_flags_ff[1:0] <= FCR_UNSECURED_CODE;
		end else if (key_done && key_ok_ff && !key_mismatch_ff
			&& flash_option_flags_ff[FCR_KEY_EN_BIT]) begin
			flash_option_flags_ff[1:0] <= FCR_UNSECURED_CODE;
		end
	end

	assign secure = (flash_option_flags_ff[1:0] != FCR_UNSECURED_CODE);
	assign secure_out = secure;
	assign access_block_out = secure && access_unsecured_in;
	assign vector_redirect_disable_out = flash_option_flags_ff[FCR_NORED_BIT];

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rdata_ff <= 8'h00;
		end else if (reg_read_in) begin
			case (reg_addr_in)
				FCR_ADDR_RATIO:   rdata_ff <= nvm_clock_ratio_ff;
				FCR_ADDR_OPTIONS: rdata_ff <= flash_option_flags_ff;
				FCR_ADDR_STATUS:  rdata_ff <= {5'h00, key_ok_ff && !key_mismatch_ff,
					secure, access_error_flag_ff};
				FCR_ADDR_KEYCTL:  rdata_ff <= {7'h00, key_access_ff};
				default:          rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end
	assign reg_rdata_out = rdata_ff;

	// Check helper: cycles since last flash clock pulse
	always_ff @(posedge clock_in) begin
		if (reset_in || !ratio_written) begin
			gap_cnt_ff  <= 10'h000;
			gap_seen_ff <= 1'b0;
		end else if (pulse_ff) begin
			gap_cnt_ff  <= 10'h001;
			gap_seen_ff <= 1'b1;
		end else begin
			gap_cnt_ff  <= gap_cnt_ff + 10'h001;
		end
	end

	// Steps of the multi-cycle behaviours
	sequence s_ratio_first;
		wr_ratio && !ratio_written;
	endsequence
	sequence s_options_load;
		state_ff == FCR_ST_LOAD;
	endsequence
	sequence s_key_start;
		key_start;
	endsequence
	sequence s_key_accept;
		key_done && key_ok_ff && !key_mismatch_ff && state_ff == FCR_ST_RUN
			&& flash_option_flags_ff[FCR_KEY_EN_BIT];
	endsequence

	a_ratio_once: assert property (@(posedge clock_in) disable iff (reset_in)
		(wr_ratio && ratio_written) |=> $stable(nvm_clock_ratio_ff))
		else $error("ratio changed after first write");
	a_flag_set: assert property (@(posedge clock_in) disable iff (reset_in)
		wr_ratio |=> nvm_clock_ratio_ff[FCR_RATIO_WRITTEN_BIT])
		else $error("written flag not set");
	a_pe_gate: assert property (@(posedge clock_in) disable iff (reset_in)
		pe_accept_out |-> ratio_written)
		else $error("program accepted before ratio");
	a_pulse_width: assert property (@(posedge clock_in) disable iff (reset_in)
		pulse_ff && nvm_clock_ratio_ff[FCR_DIV_MSB:0] != 6'h00 |=> !pulse_ff)
		else $error("pulse longer than one cycle");
	a_accerr_set: assert property (@(posedge clock_in) disable iff (reset_in)
		(pe_request_in && !ratio_written) |=> access_error_flag_ff)
		else $error("access error not set");
	a_debug_key: assert property (@(posedge clock_in) disable iff (reset_in)
		(reg_write_in && reg_from_debug_in) |=> $stable(key_index_ff))
		else $error("debug key write counted");
	a_block_sec: assert property (@(posedge clock_in) disable iff (reset_in)
		(secure && access_unsecured_in) |-> access_block_out)
		else $error("secure access not blocked");
	a_blank_unsec: assert property (@(posedge clock_in) disable iff (reset_in)
		(blank_check_ok_in && state_ff == FCR_ST_RUN) |=> !secure)
		else $error("blank check did not unsecure");
	a_opt_ro: assert property (@(posedge clock_in) disable iff (reset_in)
		(state_ff == FCR_ST_RUN && !blank_check_ok_in && !key_done)
		|=> $stable(flash_option_flags_ff))
		else $error("options changed by software");
	a_key_disabled: assert property (@(posedge clock_in) disable iff (reset_in)
		(state_ff == FCR_ST_RUN && !flash_option_flags_ff[FCR_KEY_EN_BIT]
		&& !blank_check_ok_in) |=> $stable(flash_option_flags_ff))
		else $error("unlock with key disabled");

	// Further rule checks
	a_ratio_load: assert property (@(posedge clock_in) disable iff (reset_in)
		s_ratio_first |=> (nvm_clock_ratio_ff == (8'h80 | ($past(reg_wdata_in) & 8'h7F))))
		else $error("first ratio write not stored");
	a_flag_cause: assert property (@(posedge clock_in) disable iff (reset_in)
		$rose(ratio_written) |-> $past(wr_ratio))
		else $error("written flag set without a write");
	a_pe_refuse: assert property (@(posedge clock_in) disable iff (reset_in)
		!ratio_written |-> !pe_accept_out)
		else $error("program accepted while flag clear");
	a_tick_rate: assert property (@(posedge clock_in) disable iff (reset_in)
		(nvm_clock_ratio_ff[FCR_PRESCALE_BIT] && prescale_tick) |=> !prescale_tick)
		else $error("prescaled tick on adjacent cycles");
	a_pulse_gap: assert property (@(posedge clock_in) disable iff (reset_in)
		(pulse_ff && gap_seen_ff) |-> (gap_cnt_ff == flash_period(nvm_clock_ratio_ff)))
		else $error("flash clock period wrong");
	a_opt_reload: assert property (@(posedge clock_in) disable iff (reset_in)
		s_options_load |=> (flash_option_flags_ff == $past(nonvolatile_options_byte_in)))
		else $error("options byte not reloaded");
	a_key_restart: assert property (@(posedge clock_in) disable iff (reset_in)
		s_key_start |=> (key_index_ff == 3'h0 && !key_mismatch_ff && !key_ok_ff))
		else $error("key entry not restarted");
	a_key_unlock: assert property (@(posedge clock_in) disable iff (reset_in)
		s_key_accept |=> !secure)
		else $error("matching key did not unsecure");
	a_debug_ctl: assert property (@(posedge clock_in) disable iff (reset_in)
		(wr_keyctl && reg_from_debug_in) |=> $stable(key_access_ff))
		else $error("debug write changed key access");
	a_nored_steady: assert property (@(posedge clock_in) disable iff (reset_in)
		(state_ff == FCR_ST_RUN) |=> $stable(vector_redirect_disable_out))
		else $error("redirect disable changed");
	a_unsec_sticky: assert property (@(posedge clock_in) disable iff (reset_in)
		!secure |=> !secure)
		else $error("security engaged again before reset");
	a_rdata_idle: assert property (@(posedge clock_in) disable iff (reset_in)
		!reg_read_in |=> (reg_rdata_out == 8'h00))
		else $error("read data without read strobe");
	a_accerr_clear: assert property (@(posedge clock_in) disable iff (reset_in)
		(wr_status && reg_wdata_in[FCR_STAT_ACCERR_BIT] && !pe_request_in)
		|=> !access_error_flag_ff)
		else $error("access error not cleared");
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the flash clock ratio and option flags block.
// Assumes the block alone, driven directly on its register and sequencer ports.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fcr_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
	logic        clock_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [3:0]  reg_addr_in = 4'h0;
	logic [7:0]  reg_wdata_in = 8'h00;
	logic        reg_write_in = 1'b0;
	logic        reg_read_in = 1'b0;
	logic        reg_from_debug_in = 1'b0;
	logic [7:0]  reg_rdata_out;
	logic [7:0]  nv_opt = 8'h00;
	logic [63:0] key = 64'h0;
	logic        pe_request_in = 1'b0;
	logic        blank_check_ok_in = 1'b0;
	logic        access_unsecured_in = 1'b0;
	logic        pe_accept_out;
	logic        flash_clock_pulse_out;
	logic        access_block_out;
	logic        secure_out;
	logic        vrd_out;
	logic [7:0]  exp_q[$];
	logic [7:0]  exp_v;
	logic        rd_pend = 1'b0;
	logic [5:0]  div;
	int          num_errors = 0;
	int          samples_checked = 0;
	fcr_flash_ctrl u_fcr_flash_ctrl (
		.clock_in                   (clock_in),
		.reset_in                   (reset_in),
		.reg_addr_in                (reg_addr_in),
		.reg_wdata_in               (reg_wdata_in),
		.reg_write_in               (reg_write_in),
		.reg_read_in                (reg_read_in),
		.reg_from_debug_in          (reg_from_debug_in),
		.reg_rdata_out              (reg_rdata_out),
		.nonvolatile_options_byte_in(nv_opt),
		.backdoor_compare_key_in    (key),
		.pe_request_in              (pe_request_in),
		.blank_check_ok_in          (blank_check_ok_in),
		.pe_accept_out              (pe_accept_out),
		.flash_clock_pulse_out      (flash_clock_pulse_out),
		.access_unsecured_in        (access_unsecured_in),
		.access_block_out           (access_block_out),
		.secure_out                 (secure_out),
		.vector_redirect_disable_out(vrd_out)
	);
	always #5 clock_in = ~clock_in;
	// Read data checked in the cycle after the strobe
	always @(posedge clock_in) begin
		if (rd_pend) begin
			exp_v = exp_q.pop_front();
			`CHK(reg_rdata_out, exp_v)
		end
		rd_pend <= reg_read_in;
	end
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock_in);
		num_errors++;
		stop_test();
	end
	task automatic do_reset(input logic [7:0] opt);
		@(posedge clock_in);
		reset_in <= 1'b1;
		nv_opt <= opt;
		repeat (10) @(posedge clock_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_from_debug_in <= dbg;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
		reg_from_debug_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock_in);
		reg_read_in <= 1'b0;
	endtask
	task automatic pe_try(input logic e);
		@(posedge clock_in);
		pe_request_in <= 1'b1;
		#1 `CHK(pe_accept_out, e)
		@(posedge clock_in);
		pe_request_in <= 1'b0;
	endtask
	task automatic per(input int e);
		int n;
		n = 0;
		repeat (2) begin
			do @(posedge clock_in); while (flash_clock_pulse_out !== 1'b1 && ++n < 3000);
		end
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (flash_clock_pulse_out !== 1'b1 && n < 3000);
		`CHK(n, e)
	endtask
	task automatic key_entry(input logic dbg);
		wr(FCR_ADDR_KEYCTL, 8'h01, 1'b0);
		for (int i = 0; i < 8; i++)
			wr(FCR_ADDR_KEYDATA, key[8*i +: 8], dbg);
		wr(FCR_ADDR_KEYCTL, 8'h00, 1'b0);
		repeat (2) @(posedge clock_in);
	endtask
	initial begin
		void'($urandom(43));
		div = 6'($urandom_range(15, 1));
		@(posedge clock_in);
		key <= {$urandom, $urandom};
		do_reset(8'hC3);
		`CHK(access_block_out, 1'b0)
		access_unsecured_in <= 1'b1;
		#1 `CHK(secure_out, 1'b1)
		`CHK(vrd_out, 1'b1)
		`CHK(access_block_out, 1'b1)
		rd(FCR_ADDR_OPTIONS, 8'hC3);
		rd(FCR_ADDR_RATIO, 8'h00);
		pe_try(1'b0);
		rd(FCR_ADDR_STATUS, 8'h03);
		wr(FCR_ADDR_STATUS, 8'h01, 1'b0);
		rd(FCR_ADDR_STATUS, 8'h02);
		wr(FCR_ADDR_OPTIONS, 8'h00, 1'b0);
		rd(FCR_ADDR_OPTIONS, 8'hC3);
		$display("test 1 done");
		wr(FCR_ADDR_RATIO, 8'h7E, 1'b0);
		rd(FCR_ADDR_RATIO, 8'hFE);
		wr(FCR_ADDR_RATIO, 8'h3A, 1'b0);
		rd(FCR_ADDR_RATIO, 8'hFE);
		pe_try(1'b1);
		per(504);
		$display("test 2 done");
		key_entry(1'b1);
		`CHK(secure_out, 1'b1)
		key_entry(1'b0);
		`CHK(secure_out, 1'b0)
		`CHK(access_block_out, 1'b0)
		rd(FCR_ADDR_OPTIONS, 8'hC2);
		$display("test 3 done");
		do_reset(8'h03);
		rd(FCR_ADDR_OPTIONS, 8'h03);
		`CHK(vrd_out, 1'b0)
		wr(FCR_ADDR_RATIO, {2'b00, div}, 1'b0);
		rd(FCR_ADDR_RATIO, {2'b10, div});
		per(int'(div) + 1);
		key_entry(1'b0);
		`CHK(secure_out, 1'b1)
		@(posedge clock_in);
		blank_check_ok_in <= 1'b1;
		@(posedge clock_in);
		blank_check_ok_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		`CHK(secure_out, 1'b0)
		rd(FCR_ADDR_OPTIONS, 8'h02);
		$display("test 4 done");
		repeat (3) @(posedge clock_in);
		stop_test();
	end
endmodule
`default_nettype wire
